// ===== bench/flic_core_model.sv
// Behavioural processor core: polls every four clocks, acknowledges offers.
// Assumes the controller answers on clk_i; drives at the falling edge.
`timescale 1ns/1ps
module flic_core_model #(
  parameter int ACK_DLY = 1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Controller side
  input  wire logic        int_req_i,
  input  wire logic [15:0] int_vec_i,
  output logic             inst_start_o,
  output logic             int_ack_o,
  // Bench side
  output int               taken_o,
  output logic [15:0]      last_vec_o
);
  int cnt = 1;
  int wait_q = 0;
  initial begin
    inst_start_o = 1'b0;
    int_ack_o = 1'b0;
    taken_o = 0;
    last_vec_o = 16'h0;
  end
  // First poll falls well after the reset synchroniser lets go
  always @(negedge clk_i) begin
    cnt <= rst_n_i ? cnt + 1 : 1;
    inst_start_o <= rst_n_i && (cnt % 4 == 0);
    int_ack_o <= 1'b0;
    if (int_req_i && !int_ack_o) begin
      if (wait_q >= ACK_DLY) begin
        int_ack_o <= 1'b1;
        last_vec_o <= int_vec_i;
        taken_o <= taken_o + 1;
        wait_q <= 0;
      end else begin
        wait_q <= wait_q + 1;
      end
    end
  end
endmodule // flic_core_model

// ===== bench/flic_top_properties.sv
// Checker on the controller ports: offer, acknowledge, nesting, pins, wake.
// Assumes it is bound to flic_top and everything runs on clk_i.
`timescale 1ns/1ps
module flic_top_properties
  import flic_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        ext0_pin_n_i,
  input wire logic        ext0_trigger_type_i,
  input wire logic [15:0] periph_flag_i,
  input wire logic [7:0]  int_enable_reg_a_i,
  input wire logic [7:0]  int_enable_reg_b_i,
  input wire logic        int_ack_i,
  input wire logic        inst_start_i,
  input wire logic        reti_i,
  input wire logic        int_req_o,
  input wire logic [15:0] int_vec_o,
  input wire logic [1:0]  int_level_o,
  input wire logic [3:0]  in_service_o,
  input wire logic        ext0_request_flag_o,
  input wire logic        ext1_request_flag_o,
  input wire logic        wake_o
);
  logic wake_d;
  assign wake_d = |({ext0_request_flag_o, periph_flag_i[2:1], ext1_request_flag_o,
    periph_flag_i[7], periph_flag_i[10]} & {int_enable_reg_a_i[0], int_enable_reg_a_i[6:5],
    int_enable_reg_a_i[2], int_enable_reg_b_i[1], int_enable_reg_b_i[2]});
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_GLOBAL: assert property ($rose(int_req_o) |-> $past(int_enable_reg_a_i[7]))
    else $error("offer made with global enable clear");
  AST_POLL: assert property ($rose(int_req_o) |-> $past(inst_start_i))
    else $error("offer not launched by a poll");
  AST_ACK: assert property (int_req_o && int_ack_i |=>
    !int_req_o && in_service_o[$past(int_level_o)])
    else $error("acknowledge did not retire offer into service");
  AST_TOP: assert property (in_service_o[3] && !reti_i |=> !int_req_o)
    else $error("offer while top level in service");
  AST_PREEMPT: assert property ($rose(int_req_o) && !$past(reti_i) |->
    ($past(in_service_o) >> int_level_o) == 4'h0)
    else $error("offer not above levels in service");
  AST_RETI: assert property (reti_i && in_service_o != 4'h0 |=>
    $countones(in_service_o) == $countones($past(in_service_o)) - 1)
    else $error("return did not release one level");
  AST_EDGE_CLR: assert property (ext0_trigger_type_i && int_ack_i && int_req_o &&
    int_vec_o == 16'h0003 |-> ##2 !ext0_request_flag_o)
    else $error("edge flag not cleared on vectoring");
  AST_LEVEL: assert property ((!ext0_trigger_type_i && $stable(ext0_pin_n_i)) [*6] |->
    ext0_request_flag_o == !ext0_pin_n_i)
    else $error("level flag does not follow pin");
  AST_WAKE: assert property (wake_o == $past(wake_d))
    else $error("wake output wrong for enabled sources");
endmodule // flic_top_properties

bind flic_top flic_top_properties flic_top_properties_inst (.*);

// ===== bench/flic_top_tb.sv
// Bench for the interrupt controller: gating, levels, ranking, vectors, pins, wake.
// Assumes the core model polls and acknowledges; inputs change at falling edges.
`timescale 1ns/1ps
module flic_top_tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, reti_i = 1'b0;
  logic ext0_pin_n_i = 1'b1, ext1_pin_n_i = 1'b1;
  logic ext0_trigger_type_i = 1'b0, ext1_trigger_type_i = 1'b0;
  logic serial_tx_flag_i = 1'b0, serial_rx_flag_i = 1'b0;
  logic [15:0] periph_flag_i = 16'h0;
  logic [7:0] int_enable_reg_a_i = 8'h0, int_enable_reg_b_i = 8'h0, int_enable_reg_c_i = 8'h0;
  logic [7:0] prio_low_reg_a_i = 8'h0, prio_low_reg_b_i = 8'h0, prio_low_reg_c_i = 8'h0;
  logic [7:0] prio_high_reg_a_i = 8'h0, prio_high_reg_b_i = 8'h0, prio_high_reg_c_i = 8'h0;
  logic inst_start_i, int_ack_i, int_req_o, ext0_request_flag_o, ext1_request_flag_o, wake_o;
  logic [15:0] int_vec_o, last_vec;
  logic [1:0] int_level_o, lvl_seen = 2'b00;
  logic [3:0] in_service_o;
  int taken, lv, err_count = 0, check_count = 0, cycles = 0;

  flic_top flic_top_inst (.*);
  flic_core_model #(.ACK_DLY(2)) flic_core_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .int_req_i(int_req_o), .int_vec_i(int_vec_o), .inst_start_o(inst_start_i),
    .int_ack_o(int_ack_i), .taken_o(taken), .last_vec_o(last_vec));

  always #5 clk_i = ~clk_i;

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for the core to take an offer; extra cycles let the push land
  task automatic take(input logic [15:0] v);
    int n0;
    n0 = taken;
    for (int i = 0; i < 40 && taken == n0; i++) begin
      @(negedge clk_i);
      if (int_req_o === 1'b1) lvl_seen = int_level_o;
    end
    chk(16'(taken - n0), 16'h1);
    chk(last_vec, v);
    repeat (2) @(negedge clk_i);
  endtask

  task automatic none(input int c);
    int n0;
    n0 = taken;
    repeat (c) @(negedge clk_i);
    chk(16'(taken - n0), 16'h0);
  endtask

  task automatic ret();
    reti_i = 1'b1;
    @(negedge clk_i);
    reti_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic one(input logic [15:0] f, v, input logic [1:0] s, input logic [7:0] a, b, c);
    int_enable_reg_a_i = a;
    int_enable_reg_b_i = b;
    int_enable_reg_c_i = c;
    periph_flag_i = f;
    {serial_tx_flag_i, serial_rx_flag_i} = s;
    take(v);
    periph_flag_i = 16'h0;
    {serial_tx_flag_i, serial_rx_flag_i} = 2'b00;
    ret();
  endtask

  task automatic wt(input int c);
    repeat (c) @(negedge clk_i);
  endtask

  initial begin
    wt(8);
    rst_n_i = 1'b1;
    wt(4);
    periph_flag_i[3] = 1'b1;
    int_enable_reg_a_i = 8'h02;
    none(16);
    int_enable_reg_a_i = 8'h80;
    none(16);
    int_enable_reg_a_i = 8'h82;
    take(16'h000b);
    chk(in_service_o, 4'h1);
    none(16);
    ret();
    take(16'h000b);
    periph_flag_i = 16'h0;
    ret();
    chk(in_service_o, 4'h0);
    one(16'h0002, 16'h002b, 2'b00, 8'ha0, 8'h00, 8'h00);
    one(16'h0004, 16'h0053, 2'b00, 8'hc0, 8'h00, 8'h00);
    one(16'h0200, 16'h001b, 2'b00, 8'h88, 8'h00, 8'h00);
    one(16'h0000, 16'h0023, 2'b10, 8'h90, 8'h00, 8'h00);
    one(16'h0000, 16'h0023, 2'b01, 8'h90, 8'h00, 8'h00);
    one(16'h0000, 16'h006b, 2'b10, 8'h80, 8'h40, 8'h00);
    one(16'h8000, 16'h0083, 2'b00, 8'h80, 8'h00, 8'h02);
    one(16'h0010, 16'h0033, 2'b00, 8'h80, 8'h01, 8'h00);
    one(16'h0080, 16'h003b, 2'b00, 8'h80, 8'h02, 8'h00);
    one(16'h0400, 16'h0043, 2'b00, 8'h80, 8'h04, 8'h00);
    one(16'h2000, 16'h004b, 2'b00, 8'h80, 8'h08, 8'h00);
    one(16'h0020, 16'h005b, 2'b00, 8'h80, 8'h10, 8'h00);
    one(16'h4000, 16'h0073, 2'b00, 8'h80, 8'h80, 8'h00);
    // Brownout fixed at level 1, timer1 walked through all four levels
    int_enable_reg_b_i = 8'h00;
    int_enable_reg_a_i = 8'ha8;
    prio_low_reg_a_i = 8'h20;
    for (lv = 0; lv < 4; lv++) begin
      {prio_high_reg_a_i[3], prio_low_reg_a_i[3]} = lv[1:0];
      periph_flag_i = 16'h0202;
      take(lv > 1 ? 16'h001b : 16'h002b);
      chk(16'(lvl_seen), lv > 1 ? 16'(lv) : 16'h1);
      periph_flag_i = 16'h0;
      ret();
    end
    // Timer0 level 1, timer1 level 2, brownout level 0
    prio_low_reg_a_i = 8'h02;
    prio_high_reg_a_i = 8'h08;
    int_enable_reg_a_i = 8'haa;
    periph_flag_i = 16'h0008;
    take(16'h000b);
    periph_flag_i = 16'h000a;
    none(16);
    periph_flag_i = 16'h020a;
    take(16'h001b);
    chk(in_service_o, 4'h6);
    periph_flag_i = 16'h0;
    ret();
    chk(in_service_o, 4'h2);
    ret();
    prio_low_reg_a_i = 8'h00;
    prio_high_reg_a_i = 8'h00;
    // Edge on ext0: high then low for one machine cycle each
    int_enable_reg_a_i = 8'h84;
    ext0_trigger_type_i = 1'b1;
    ext0_pin_n_i = 1'b0;
    wt(2);
    ext0_pin_n_i = 1'b1;
    wt(4);
    chk(ext0_request_flag_o, 1'b1);
    int_enable_reg_a_i = 8'h85;
    take(16'h0003);
    chk(ext0_request_flag_o, 1'b0);
    ret();
    // Level on ext1, held until taken
    ext1_pin_n_i = 1'b0;
    take(16'h0013);
    ret();
    take(16'h0013);
    ext1_pin_n_i = 1'b1;
    wt(8);
    chk(ext1_request_flag_o, 1'b0);
    ret();
    ext1_pin_n_i = 1'b0;
    wt(1);
    ext1_pin_n_i = 1'b1;
    repeat (6) begin
      wt(1);
      chk(ext1_request_flag_o, 1'b0);
    end
    int_enable_reg_a_i = 8'h04;
    ext1_pin_n_i = 1'b0;
    wt(10);
    chk(wake_o, 1'b1);
    ext1_pin_n_i = 1'b1;
    int_enable_reg_a_i = 8'h02;
    periph_flag_i = 16'h0008;
    wt(10);
    chk(wake_o, 1'b0);
    int_enable_reg_b_i = 8'h02;
    periph_flag_i = 16'h0080;
    wt(4);
    chk(wake_o, 1'b1);
    // Level mode on ext0: flag follows the unfiltered pin both ways
    ext0_trigger_type_i = 1'b0;
    ext0_pin_n_i = 1'b0;
    wt(10);
    chk(ext0_request_flag_o, 1'b1);
    ext0_pin_n_i = 1'b1;
    wt(10);
    chk(ext0_request_flag_o, 1'b0);
    report_and_stop();
  end
endmodule // flic_top_tb

// ===== pkg/flic_ext_if.sv
// Carrier between the controller core and one external pin detector.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
interface flic_ext_if;
  logic smp;
  logic mode;
  logic clr;
  logic pin;
  logic req;
  modport ctl (output smp, output mode, output clr, output pin, input req);
  modport ext (input smp, input mode, input clr, input pin, output req);
endinterface

// ===== pkg/flic_pkg.sv
// Constants for the four-level interrupt controller: slot layout, vectors, timing.
// Assumes sources are numbered by fixed arbitration rank, slot 0 ranked first.
package flic_pkg;

  localparam int NSLOT = 16;
  localparam int NEXT  = 2;

  // Slots in polling order; slot 8 has no source and never requests
  localparam int SLOT_EXT0 = 0;
  localparam int SLOT_EXT1 = 6;
  localparam int SLOT_NONE = 8;
  localparam int SLOT_STX  = 11;
  localparam int SLOT_SER  = 12;

  // Enable/priority bit select per slot: {reg[1:0], bit[2:0]}, reg 0=a, 1=b, 2=c
  localparam logic [NSLOT*5-1:0] SLOT_SEL = {
    5'h11, 5'h0f, 5'h0b, 5'h04, 5'h0e, 5'h0a, 5'h03, 5'h00,
    5'h09, 5'h02, 5'h0c, 5'h08, 5'h01, 5'h06, 5'h05, 5'h00
  };

  // Vector address per slot, slot 15 first
  localparam logic [NSLOT*16-1:0] SLOT_VEC = {
    16'h0083, 16'h0073, 16'h004b, 16'h0023,
    16'h006b, 16'h0043, 16'h001b, 16'h0000,
    16'h003b, 16'h0013, 16'h005b, 16'h0033,
    16'h000b, 16'h0053, 16'h002b, 16'h0003
  };

  // Slots allowed to wake the core: ext0, brownout, watchdog, ext1, keypad, comparator
  localparam logic [NSLOT-1:0] WAKE_MASK = 16'h04c7;

  // Global enable position in enable register a
  localparam int EN_GLOBAL_BIT = 7;
  // Serial enables: combined in reg a, transmit-only in reg b
  localparam int EN_SER_BIT = 4;
  localparam int EN_STX_BIT = 6;

  // Clocks per machine cycle; external pins are sampled once per machine cycle
  localparam int          MCYC_CLKS = 2;
  localparam logic [3:0]  MCYC_LAST = 4'(MCYC_CLKS - 1);

  localparam logic [3:0]  ISVC_RST  = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_VEC  = 2'b11
  } flic_state_t;

endpackage

// ===== rtl/flic_ext_pin.sv
// External interrupt pin detector: optional glitch filter, sampling, edge/level flag.
// Assumes an active-low pin synchronous to clk_i and a one-cycle sample strobe.
`timescale 1ns/1ps
module flic_ext_pin
  import flic_pkg::*;
#(
  parameter bit GLITCH = 1'b0
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Controller side
  flic_ext_if.ext   bus
);

  logic lvl;
  logic smp_q;
  logic flag_q;

  generate
    if (GLITCH) begin : g_filt
      logic r1_q;
      logic f_q;
      // Level moves only after two equal raw samples in a row
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          r1_q <= 1'b1;
          f_q  <= 1'b1;
        end else begin
          r1_q <= bus.pin;
          if (bus.pin == r1_q) begin
            f_q <= bus.pin; // [R21]
          end
        end
      end
      assign lvl = f_q;
    end else begin : g_raw
      assign lvl = bus.pin; // [R21]
    end
  endgenerate

  // One sample per machine cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp_q <= 1'b1;
    end else if (bus.smp) begin
      smp_q <= lvl; // [R13]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= 1'b0;
    end else if (!bus.mode) begin
      flag_q <= ~smp_q; // [R11] [R18] [R17]
    end else if (bus.smp && smp_q && !lvl) begin
      // Set wins over a clear in the same cycle
      flag_q <= 1'b1; // [R12]
    end else if (bus.clr) begin
      flag_q <= 1'b0; // [R15]
    end
  end

  assign bus.req = flag_q;

endmodule // flic_ext_pin

// ===== rtl/flic_top.sv
// Four-level interrupt controller: enables, priorities, arbitration, vectoring,
// nesting and power-down wake. Assumes the core pulses inst_start_i at each
// instruction start, int_ack_i when it vectors, reti_i on return from service.
`timescale 1ns/1ps

// Behaviour
// [R1] Per-source enable gates every request
// [R2] Global enable clear blocks all delivery
// [R3] Two priority bits select level 0..3
// [R4] Preempt only by strictly higher level
// [R5] Level 3 in service blocks everything
// [R6] Higher level wins among simultaneous requests
// [R7] Poll at instruction start, fixed order
// [R8] Fixed ranking only breaks equal-level ties
// [R9] Fixed vector address per source
// [R10] Serial shared vector, optional transmit vector
// [R11] Level mode requests on low sample
// [R12] Edge mode sets flag on high-low
// [R13] Pins sampled once per machine cycle
// [R14] Edge source holds high, then low
// [R15] Edge flag cleared when core vectors
// [R16] Level source holds until interrupt taken
// [R17] Still-low level pin re-interrupts after return
// [R18] Level flag tracks sampled pin
// [R19] Enabled level external interrupt wakes core
// [R20] Only listed sources wake from power-down
// [R21] External 1 filtered, external 0 not
// [R22] Track in-service levels, release on return
module flic_top
  import flic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // External interrupt pins, active low
  input  wire logic        ext0_pin_n_i,
  input  wire logic        ext1_pin_n_i,
  // Trigger types: 0 level, 1 falling edge
  input  wire logic        ext0_trigger_type_i,
  input  wire logic        ext1_trigger_type_i,
  // Peripheral flags by slot; external, serial and spare slots ignored
  input  wire logic [15:0] periph_flag_i,
  input  wire logic        serial_tx_flag_i,
  input  wire logic        serial_rx_flag_i,
  // Enable and priority registers
  input  wire logic [7:0]  int_enable_reg_a_i,
  input  wire logic [7:0]  int_enable_reg_b_i,
  input  wire logic [7:0]  int_enable_reg_c_i,
  input  wire logic [7:0]  prio_low_reg_a_i,
  input  wire logic [7:0]  prio_low_reg_b_i,
  input  wire logic [7:0]  prio_low_reg_c_i,
  input  wire logic [7:0]  prio_high_reg_a_i,
  input  wire logic [7:0]  prio_high_reg_b_i,
  input  wire logic [7:0]  prio_high_reg_c_i,
  // Core handshake
  input  wire logic        inst_start_i,
  input  wire logic        int_ack_i,
  input  wire logic        reti_i,
  output logic             int_req_o,
  output logic [15:0]      int_vec_o,
  output logic [1:0]       int_level_o,
  output logic [3:0]       in_service_o,
  // Status
  output logic             ext0_request_flag_o,
  output logic             ext1_request_flag_o,
  output logic             wake_o
);

  logic              rst_s1_q;
  logic              rst_n;
  logic [3:0]        mc_cnt_q;
  logic              smp_q;
  logic              clr0_q;
  logic              clr1_q;
  logic [23:0]       en_all;
  logic [23:0]       lo_all;
  logic [23:0]       hi_all;
  logic [15:0]       flag;
  logic [15:0]       req;
  logic [1:0]        lvl [NSLOT];
  logic [1:0]        ext_req;
  logic              found;
  logic [3:0]        best;
  logic [1:0]        best_lvl;
  logic              allow;
  logic              ser_flag;
  logic              stx_flag;
  flic_state_t       st_q;
  logic              req_q;
  logic [15:0]       vec_q;
  logic [1:0]        lvl_q;
  logic [3:0]        slot_q;
  logic [3:0]        isvc_q;
  logic [3:0]        isvc_rel;
  logic              wake_q;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Machine cycle sample strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mc_cnt_q <= 4'h0;
      smp_q    <= 1'b0;
    end else begin
      smp_q <= (mc_cnt_q == MCYC_LAST); // [R13]
      if (mc_cnt_q == MCYC_LAST) begin
        mc_cnt_q <= 4'h0;
      end else begin
        mc_cnt_q <= mc_cnt_q + 4'h1;
      end
    end
  end

  // External pin detectors; only external 1 carries the glitch filter
  flic_ext_if ext_if [NEXT] ();

  assign ext_if[0].smp  = smp_q;
  assign ext_if[0].mode = ext0_trigger_type_i;
  assign ext_if[0].clr  = clr0_q;
  assign ext_if[0].pin  = ext0_pin_n_i;
  assign ext_if[1].smp  = smp_q;
  assign ext_if[1].mode = ext1_trigger_type_i;
  assign ext_if[1].clr  = clr1_q;
  assign ext_if[1].pin  = ext1_pin_n_i;
  assign ext_req[0]     = ext_if[0].req;
  assign ext_req[1]     = ext_if[1].req;

  flic_ext_pin #(.GLITCH(1'b0)) u_ext0 (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .bus     (ext_if[0])
  );

  flic_ext_pin #(.GLITCH(1'b1)) u_ext1 (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .bus     (ext_if[1])
  );

  assign en_all = {int_enable_reg_c_i, int_enable_reg_b_i, int_enable_reg_a_i};
  assign lo_all = {prio_low_reg_c_i, prio_low_reg_b_i, prio_low_reg_a_i};
  assign hi_all = {prio_high_reg_c_i, prio_high_reg_b_i, prio_high_reg_a_i};

  // Transmit goes to its own vector only while its own enable is set
  assign stx_flag = serial_tx_flag_i & int_enable_reg_b_i[EN_STX_BIT]; // [R10]
  assign ser_flag = serial_rx_flag_i
                  | (serial_tx_flag_i & ~int_enable_reg_b_i[EN_STX_BIT]); // [R10]

  // Per-slot request and level
  generate
    for (genvar i = 0; i < NSLOT; i++) begin : g_slot
      localparam logic [4:0] SEL = SLOT_SEL[i*5 +: 5];
      if (i == SLOT_EXT0) begin : g_e0
        assign flag[i] = ext_req[0];
      end else if (i == SLOT_EXT1) begin : g_e1
        assign flag[i] = ext_req[1];
      end else if (i == SLOT_SER) begin : g_ser
        assign flag[i] = ser_flag;
      end else if (i == SLOT_STX) begin : g_stx
        assign flag[i] = stx_flag;
      end else if (i == SLOT_NONE) begin : g_none
        assign flag[i] = 1'b0;
      end else begin : g_per
        assign flag[i] = periph_flag_i[i];
      end
      assign req[i] = flag[i] & en_all[SEL]; // [R1]
      assign lvl[i] = {hi_all[SEL], lo_all[SEL]}; // [R3]
    end
  endgenerate

  // Pick the highest level; ties go to the lowest slot, the first in rank
  always_comb begin
    found    = 1'b0;
    best     = 4'h0;
    best_lvl = 2'b00;
    for (int i = 0; i < NSLOT; i++) begin
      if (req[i] && (!found || lvl[i] > best_lvl)) begin // [R6] [R8]
        found    = 1'b1;
        best     = 4'(i);
        best_lvl = lvl[i];
      end
    end
  end

  // Delivery needs global enable and a level above anything in service
  always_comb begin
    allow = found && int_enable_reg_a_i[EN_GLOBAL_BIT]; // [R2]
    if (isvc_q[3]) begin
      allow = 1'b0; // [R5]
    end else if (isvc_q[2] && best_lvl <= 2'd2) begin
      allow = 1'b0; // [R4]
    end else if (isvc_q[1] && best_lvl <= 2'd1) begin
      allow = 1'b0; // [R4]
    end else if (isvc_q[0] && best_lvl == 2'd0) begin
      allow = 1'b0; // [R4]
    end
  end

  // Return releases the highest level in service
  always_comb begin
    isvc_rel = isvc_q;
    if (reti_i) begin
      if (isvc_q[3]) begin
        isvc_rel[3] = 1'b0; // [R22]
      end else if (isvc_q[2]) begin
        isvc_rel[2] = 1'b0;
      end else if (isvc_q[1]) begin
        isvc_rel[1] = 1'b0;
      end else begin
        isvc_rel[0] = 1'b0;
      end
    end
  end

  // Delivery sequence; a pending request is re-polled each instruction start
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= ST_IDLE;
      req_q  <= 1'b0;
      vec_q  <= 16'h0000;
      lvl_q  <= 2'b00;
      slot_q <= 4'h0;
    end else begin
      case (st_q)
        ST_IDLE, ST_REQ: begin
          if (st_q == ST_REQ && int_ack_i) begin
            st_q  <= ST_VEC;
            req_q <= 1'b0;
          end else if (inst_start_i) begin // [R7]
            req_q  <= allow;
            vec_q  <= SLOT_VEC[best*16 +: 16]; // [R9]
            lvl_q  <= best_lvl;
            slot_q <= best;
            st_q   <= allow ? ST_REQ : ST_IDLE;
          end
        end
        ST_VEC: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q  <= ST_IDLE;
          req_q <= 1'b0;
        end
      endcase
    end
  end

  // Nesting: push on vectoring, release on return
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      isvc_q <= ISVC_RST;
    end else if (st_q == ST_REQ && int_ack_i) begin
      isvc_q <= isvc_rel | (4'h1 << lvl_q); // [R22]
    end else begin
      isvc_q <= isvc_rel; // [R22]
    end
  end

  // Edge flags of the external pins clear when their vector is taken
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clr0_q <= 1'b0;
      clr1_q <= 1'b0;
    end else begin
      clr0_q <= st_q == ST_REQ && int_ack_i && slot_q == 4'(SLOT_EXT0); // [R15]
      clr1_q <= st_q == ST_REQ && int_ack_i && slot_q == 4'(SLOT_EXT1); // [R15]
    end
  end

  // Wake ignores the global enable; a level-mode pin holds its request [R16]
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= |(req & WAKE_MASK); // [R19] [R20]
    end
  end

  assign int_req_o           = req_q;
  assign int_vec_o           = vec_q;
  assign int_level_o         = lvl_q;
  assign in_service_o        = isvc_q;
  assign ext0_request_flag_o = ext_req[0];
  assign ext1_request_flag_o = ext_req[1];
  assign wake_o              = wake_q;

endmodule // flic_top
